// [design/eeprom_pkg.sv]
// Shared constants for the serial nonvolatile memory link and its controller.
package eeprom_pkg;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned T_PROG_US = 5000;
   localparam int unsigned PROG_CNT_W = 18;
   localparam logic [PROG_CNT_W-1:0] PROG_CYC_DEFAULT = PROG_CNT_W'(T_PROG_US * CLK_MHZ);
   localparam int unsigned T_SCK_HALF_NS = 300;
   localparam logic [4:0] SCK_HALF_CYC = 5'((T_SCK_HALF_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] STATUS_RST = 8'h30;
   localparam int unsigned ACTIVE_POS = 0;
   localparam int unsigned PERMIT_POS = 1;
   localparam int unsigned LEVEL_LSB = 2;
   localparam int unsigned TSEL_LSB = 4;
   localparam logic [7:0] OPC_ARM = 8'h06;
   localparam logic [7:0] OPC_DISARM = 8'h04;
   localparam logic [7:0] OPC_STAT_RD = 8'h05;
   localparam logic [7:0] OPC_STAT_WR = 8'h01;
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_WRITE = 8'h02;
   localparam logic [7:0] OPC_A8_MASK = 8'hF7;
   localparam int unsigned UPPER_ADDR_POS = 3;
   localparam logic [1:0] LVL_QUARTER = 2'h1;
   localparam logic [1:0] LVL_HALF = 2'h2;
   localparam logic [1:0] LVL_ALL = 2'h3;
   localparam logic [3:0] REG_XFER = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CONFIG = 4'h8;
   localparam int unsigned XFER_LAST_POS = 8;
   localparam int unsigned ST_BUSY_POS = 0;
   localparam int unsigned ST_OPEN_POS = 1;
   localparam int unsigned ST_RX_LSB = 8;
   localparam logic CONFIG_WP_RST = 1'b1;
   typedef enum logic [4:0] {
      OP_NONE = 5'b00001,
      OP_STAT_RD = 5'b00010,
      OP_STAT_WR = 5'b00100,
      OP_READ = 5'b01000,
      OP_WRITE = 5'b10000
   } op_e;
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_LEAD = 6'b000010,
      H_LOW = 6'b000100,
      H_HIGH = 6'b001000,
      H_LAG = 6'b010000,
      H_GAP = 6'b100000
   } host_state_e;
endpackage

// [design/spi_link_if.sv]
// Four-wire serial link plus write-protect pin between controller and memory.
`timescale 1ns/10ps
interface spi_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic write_protect_n;
   logic miso_line;
   // The released output line is modelled as pulled high.
   assign miso_line = miso_oe ? miso : 1'b1;
   modport device (input sck, input cs_n, input mosi, input write_protect_n, output miso, output miso_oe);
   modport host (output sck, output cs_n, output mosi, output write_protect_n, input miso_line);
endinterface

// [design/spi_eeprom_device.sv]
// Serial nonvolatile memory: command decode, status byte, array, programming.
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module spi_eeprom_device #(
   parameter logic [eeprom_pkg::PROG_CNT_W-1:0] PROG_CYCLES = eeprom_pkg::PROG_CYC_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   spi_link_if.device link,
   output logic write_active_o,
   output logic [1:0] timeout_select_o
);
   import eeprom_pkg::*;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [3:0] raw;
   logic [3:0] s1_r;
   logic [3:0] s2_r;
   logic [3:0] s3_r;
   logic [3:0] flt_r;
   logic [3:0] flt_d_r;
   assign raw = {link.write_protect_n, link.mosi, link.cs_n, link.sck};

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r <= 4'hA;
         s2_r <= 4'hA;
         s3_r <= 4'hA;
         flt_r <= 4'hA;
         flt_d_r <= 4'hA;
      end else if (ce_i) begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_r <= (flt_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
         flt_d_r <= flt_r;
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic si;
   logic wp_ok;
   assign sck_rise = flt_r[0] & ~flt_d_r[0];
   assign sck_fall = ~flt_r[0] & flt_d_r[0];
   assign cs_fall = ~flt_r[1] & flt_d_r[1];
   assign cs_rise = flt_r[1] & ~flt_d_r[1];
   assign si = flt_r[2];
   assign wp_ok = flt_r[3];

   // ***************************************************************
   // Frame and byte tracking
   // ***************************************************************
   logic active_r;
   logic [2:0] bit_cnt_r;
   logic [4:0] byte_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] rx_byte;
   logic byte_done;
   assign rx_byte = {shift_r[6:0], si};
   assign byte_done = sck_rise & active_r & (bit_cnt_r == 3'h7);

   // Nothing is accepted until a falling select edge opens a frame.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 5'h00;
         shift_r <= 8'h00;
      end else if (ce_i) begin
         if (cs_fall) begin
            active_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            byte_cnt_r <= 5'h00;
         end else if (cs_rise) begin
            active_r <= 1'b0;
         end else if (sck_rise && active_r) begin
            shift_r <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7 && byte_cnt_r != 5'h1F) begin
               byte_cnt_r <= byte_cnt_r + 5'h01;
            end
         end
      end
   end

   // ***************************************************************
   // Status bits and protection
   // ***************************************************************
   logic busy_r;
   logic permit_r;
   logic [1:0] tsel_r;
   logic [1:0] level_r;
   logic [PROG_CNT_W-1:0] prog_cnt_r;
   logic prog_done;
   logic [7:0] status_byte;
   logic stat_go;
   logic write_go;
   op_e op_r;
   logic [7:0] wr_stat_r;
   assign status_byte = {2'b00, tsel_r, level_r, permit_r, busy_r};
   assign prog_done = busy_r & (prog_cnt_r == '0);

   function automatic logic protected_at(input logic [8:0] a, input logic [1:0] lvl);
      logic hit;
      hit = 1'b0;
      case (lvl)
         LVL_QUARTER: hit = (a[8:7] == 2'b11);
         LVL_HALF: hit = a[8];
         LVL_ALL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Pin low wins over an arm arriving in the same cycle; an arm wins over the end of programming.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         permit_r <= STATUS_RST[PERMIT_POS];
      end else if (ce_i) begin
         if (!wp_ok) begin
            permit_r <= 1'b0;
         end else if (byte_done && byte_cnt_r == 5'h00 && rx_byte == OPC_ARM) begin
            permit_r <= 1'b1;
         end else if ((byte_done && byte_cnt_r == 5'h00 && rx_byte == OPC_DISARM) || prog_done) begin
            permit_r <= 1'b0;
         end
      end
   end

   // Protect and timeout bits change only through a permitted status write.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tsel_r <= STATUS_RST[TSEL_LSB+:2];
         level_r <= STATUS_RST[LEVEL_LSB+:2];
      end else if (ce_i && stat_go) begin
         tsel_r <= wr_stat_r[TSEL_LSB+:2];
         level_r <= wr_stat_r[LEVEL_LSB+:2];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_r <= STATUS_RST[ACTIVE_POS];
         prog_cnt_r <= '0;
      end else if (ce_i) begin
         if (stat_go || write_go) begin
            busy_r <= 1'b1;
            prog_cnt_r <= PROG_CYCLES - 1'b1;
         end else if (prog_done) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            prog_cnt_r <= prog_cnt_r - 1'b1;
         end
      end
   end

   // ***************************************************************
   // Command decode, address and page buffer
   // ***************************************************************
   logic [7:0] mem [0:511];
   logic [8:0] addr_r;
   logic [7:0] pg_data_r [0:15];
   logic [15:0] pg_valid_r;
   logic [15:0] pg_free;
   logic [7:0] out_r;

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         pg_free[i] = pg_valid_r[i] & ~protected_at({addr_r[8:4], 4'(i)}, level_r);
      end
   end

   assign stat_go = cs_rise & (op_r == OP_STAT_WR) & (byte_cnt_r == 5'h02) & (bit_cnt_r == 3'h0)
                    & permit_r & wp_ok & ~busy_r;
   assign write_go = cs_rise & (op_r == OP_WRITE) & (byte_cnt_r >= 5'h03) & (bit_cnt_r == 3'h0)
                     & permit_r & wp_ok & ~busy_r & (|pg_free);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         op_r <= OP_NONE;
         addr_r <= 9'h000;
         wr_stat_r <= 8'h00;
         pg_valid_r <= 16'h0000;
         out_r <= 8'h00;
      end else if (ce_i) begin
         if (cs_fall) begin
            op_r <= OP_NONE;
         end else if (byte_done && byte_cnt_r == 5'h00) begin
            op_r <= OP_NONE;
            if (rx_byte == OPC_STAT_RD) begin
               op_r <= OP_STAT_RD;
               out_r <= status_byte;
            end else if (rx_byte == OPC_STAT_WR && !busy_r) begin
               op_r <= OP_STAT_WR;
            end else if ((rx_byte & OPC_A8_MASK) == OPC_READ) begin
               op_r <= OP_READ;
               addr_r[8] <= rx_byte[UPPER_ADDR_POS];
            end else if ((rx_byte & OPC_A8_MASK) == OPC_WRITE && !busy_r) begin
               op_r <= OP_WRITE;
               addr_r[8] <= rx_byte[UPPER_ADDR_POS];
            end
         end else if (byte_done) begin
            case (op_r)
               OP_STAT_RD: out_r <= status_byte;
               OP_STAT_WR: wr_stat_r <= rx_byte;
               OP_READ: begin
                  if (byte_cnt_r == 5'h01) begin
                     out_r <= mem[{addr_r[8], rx_byte}];
                     addr_r <= {addr_r[8], rx_byte} + 9'h001;
                  end else begin
                     out_r <= mem[addr_r];
                     addr_r <= addr_r + 9'h001;
                  end
               end
               OP_WRITE: begin
                  if (byte_cnt_r == 5'h01) begin
                     addr_r[7:0] <= rx_byte;
                     pg_valid_r <= 16'h0000;
                  end else begin
                     pg_valid_r[addr_r[3:0]] <= 1'b1;
                     addr_r[3:0] <= addr_r[3:0] + 4'h1;
                  end
               end
               default: op_r <= OP_NONE;
            endcase
         end else if (sck_fall && active_r) begin
            out_r <= {out_r[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && byte_done && op_r == OP_WRITE && byte_cnt_r != 5'h01) begin
         pg_data_r[addr_r[3:0]] <= rx_byte;
      end
   end

   // Array cells have no reset; they keep content across resets like the real cells.
   always_ff @(posedge clk_i) begin
      if (ce_i && write_go) begin
         for (int i = 0; i < 16; i++) begin
            if (pg_free[i]) begin
               mem[{addr_r[8:4], 4'(i)}] <= pg_data_r[i];
            end
         end
      end
   end

   // ***************************************************************
   // Serial output
   // ***************************************************************
   logic so_r;
   logic so_oe_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         so_r <= 1'b0;
         so_oe_r <= 1'b0;
      end else if (ce_i) begin
         if (!active_r || cs_rise) begin
            so_oe_r <= 1'b0;
         end else if (sck_fall && (op_r == OP_STAT_RD || op_r == OP_READ)) begin
            so_r <= out_r[7];
            so_oe_r <= 1'b1;
         end
      end
   end

   assign link.miso = so_r;
   assign link.miso_oe = so_oe_r;
   assign write_active_o = busy_r;
   assign timeout_select_o = tsel_r;
endmodule

// [design/spi_eeprom_host.sv]
// Bus-programmed controller that drives the serial memory link byte by byte.
`timescale 1ns/10ps
module spi_eeprom_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   spi_link_if.host link
);
   import eeprom_pkg::*;

   // ***************************************************************
   // Bus slave
   // ***************************************************************
   host_state_e state_r;
   logic ap_wr_r;
   logic [3:0] ap_addr_r;
   logic [31:0] hrdata_r;
   logic wp_r;
   logic cs_n_r;
   logic [7:0] rx_r;
   logic start;
   logic ap_take;
   assign ap_take = hsel_i & htrans_i[1] & hready_i;
   assign start = ap_wr_r & (ap_addr_r == REG_XFER) & (state_r == H_IDLE);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ap_wr_r <= 1'b0;
         ap_addr_r <= 4'h0;
         hrdata_r <= 32'h0000_0000;
      end else if (ce_i) begin
         ap_wr_r <= ap_take & hwrite_i;
         ap_addr_r <= haddr_i[3:0];
         if (ap_take && !hwrite_i) begin
            case (haddr_i[3:0])
               REG_STATUS: hrdata_r <= {16'h0000, rx_r, 6'h00, ~cs_n_r, state_r != H_IDLE};
               REG_CONFIG: hrdata_r <= {31'h0000_0000, wp_r};
               default: hrdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r <= CONFIG_WP_RST;
      end else if (ce_i && ap_wr_r && ap_addr_r == REG_CONFIG) begin
         wp_r <= hwdata_i[0];
      end
   end

   assign hrdata_o = hrdata_r;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // ***************************************************************
   // Link side
   // ***************************************************************
   logic m1_r;
   logic m2_r;
   logic m3_r;
   logic mflt_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         m1_r <= 1'b1;
         m2_r <= 1'b1;
         m3_r <= 1'b1;
         mflt_r <= 1'b1;
      end else if (ce_i) begin
         m1_r <= link.miso_line;
         m2_r <= m1_r;
         m3_r <= m2_r;
         if (m2_r == m3_r) begin
            mflt_r <= m3_r;
         end
      end
   end

   // Half periods are long enough to cover both ends' three-stage input filters.
   logic [7:0] tx_r;
   logic last_r;
   logic [2:0] bit_r;
   logic [4:0] tmr_r;
   logic sck_r;
   logic mosi_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= H_IDLE;
         tx_r <= 8'h00;
         last_r <= 1'b0;
         bit_r <= 3'h7;
         tmr_r <= 5'h00;
         sck_r <= 1'b0;
         cs_n_r <= 1'b1;
         mosi_r <= 1'b0;
         rx_r <= 8'h00;
      end else if (ce_i) begin
         if (tmr_r != 5'h00) begin
            tmr_r <= tmr_r - 5'h01;
         end
         case (state_r)
            H_IDLE: begin
               if (start) begin
                  tx_r <= hwdata_i[7:0];
                  last_r <= hwdata_i[XFER_LAST_POS];
                  bit_r <= 3'h7;
                  tmr_r <= SCK_HALF_CYC - 5'h01;
                  if (cs_n_r) begin
                     cs_n_r <= 1'b0;
                     state_r <= H_LEAD;
                  end else begin
                     mosi_r <= hwdata_i[7];
                     state_r <= H_LOW;
                  end
               end
            end
            H_LEAD: begin
               if (tmr_r == 5'h00) begin
                  mosi_r <= tx_r[7];
                  tmr_r <= SCK_HALF_CYC - 5'h01;
                  state_r <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmr_r == 5'h00) begin
                  sck_r <= 1'b1;
                  rx_r <= {rx_r[6:0], mflt_r};
                  tmr_r <= SCK_HALF_CYC - 5'h01;
                  state_r <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tmr_r == 5'h00) begin
                  sck_r <= 1'b0;
                  tmr_r <= SCK_HALF_CYC - 5'h01;
                  if (bit_r != 3'h0) begin
                     bit_r <= bit_r - 3'h1;
                     mosi_r <= tx_r[bit_r - 3'h1];
                     state_r <= H_LOW;
                  end else if (last_r) begin
                     state_r <= H_LAG;
                  end else begin
                     state_r <= H_IDLE;
                  end
               end
            end
            H_LAG: begin
               if (tmr_r == 5'h00) begin
                  cs_n_r <= 1'b1;
                  tmr_r <= SCK_HALF_CYC - 5'h01;
                  state_r <= H_GAP;
               end
            end
            H_GAP: begin
               if (tmr_r == 5'h00) begin
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   assign link.sck = sck_r;
   assign link.cs_n = cs_n_r;
   assign link.mosi = mosi_r;
   assign link.write_protect_n = wp_r;
endmodule

// [dv/spi_eeprom_properties.sv]
// Timing and framing properties watched on the serial memory link.
`timescale 1ns/10ps
module spi_eeprom_properties #(
   parameter logic [17:0] PROG_CYCLES = 18'h00032
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic write_active_o
);
   logic [17:0] busy_cnt_r;
   // The length is judged with one cycle of slack, since the flag is a registered copy.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_cnt_r <= 18'h00000;
      end else if (write_active_o) begin
         busy_cnt_r <= busy_cnt_r + 18'h00001;
      end else begin
         busy_cnt_r <= 18'h00000;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence sck_high_phase;
      sck[*8] ##1 sck[*3] ##[1:2] !sck;
   endsequence
   sequence lead_quiet;
      !sck[*8];
   endsequence
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("serial clock active outside a frame");
   a_sck_high_width: assert property ($rose(sck) |-> sck_high_phase)
      else $error("serial clock high phase has the wrong width");
   a_cs_lead_quiet: assert property ($fell(cs_n) |-> lead_quiet)
      else $error("serial clock moved too soon after select fell");
   a_mosi_steady_high: assert property ((sck && $past(sck)) |-> $stable(mosi))
      else $error("input data changed while the clock was high");
   a_miso_on_fall: assert property ((miso_oe && $past(miso_oe) && $changed(miso)) |-> !sck)
      else $error("output data changed while the clock was high");
   a_oe_in_frame: assert property ($rose(miso_oe) |-> !cs_n)
      else $error("output driven without a selected frame");
   a_oe_release: assert property ($rose(cs_n) |-> ##[1:8] !miso_oe)
      else $error("output not released after select rose");
   a_commit_on_cs: assert property ($rose(write_active_o) |-> cs_n)
      else $error("programming started inside a frame");
   a_busy_length: assert property ($fell(write_active_o) |-> (busy_cnt_r - PROG_CYCLES + 18'h00001) <= 18'h00002)
      else $error("programming time differs from the set count");
endmodule

// [dv/tb_spi_eeprom_status_array_access.sv]
// Testbench joining the bus controller and the memory over the serial link.
`timescale 1ns/10ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb_spi_eeprom_status_array_access;
   import eeprom_pkg::*;
   localparam logic [17:0] PROG = 18'h007D0;
   logic clk_i, rst_i, hsel, hwrite, hready, hresp, write_active;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, tsel;
   int num_errors, n_tests;
   spi_link_if spi_link_if_i();
   spi_eeprom_host spi_eeprom_host_i(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .link(spi_link_if_i.host));
   spi_eeprom_device #(.PROG_CYCLES(PROG)) spi_eeprom_device_i(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .link(spi_link_if_i.device), .write_active_o(write_active), .timeout_select_o(tsel));
   spi_eeprom_properties #(.PROG_CYCLES(PROG)) spi_eeprom_properties_i(.clk_i(clk_i), .rst_i(rst_i),
      .sck(spi_link_if_i.sck), .cs_n(spi_link_if_i.cs_n), .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso),
      .miso_oe(spi_link_if_i.miso_oe), .write_active_o(write_active));
   always #12.5 clk_i = ~clk_i;
   task automatic summarize();
      $display("Errors %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic hang();
      num_errors++;
      $display("MISMATCH %0t wait ran out", $time);
      summarize();
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge clk_i);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) hang();
         @(posedge clk_i);
      end
   endtask
   // One single-word transfer; read data is taken at the edge that ends the data phase.
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {28'h0000000, a};
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] rx);
      logic [31:0] d;
      int n;
      bus(1'b1, REG_XFER, {23'h000000, last, b}, d);
      n = 0;
      do begin
         bus(1'b0, REG_STATUS, 32'h00000000, d);
         n++;
      end while (d[ST_BUSY_POS] !== 1'b0 && n < 400);
      if (n >= 400) hang();
      rx = d[15:8];
   endtask
   task automatic cmd(input logic [7:0] b);
      logic [7:0] r;
      xfer(b, 1'b1, r);
   endtask
   task automatic rd_status(output logic [7:0] s);
      logic [7:0] r;
      xfer(OPC_STAT_RD, 1'b0, r);
      xfer(8'h00, 1'b1, s);
   endtask
   task automatic wait_idle(output logic [7:0] s);
      int n;
      n = 0;
      do begin
         rd_status(s);
         n++;
      end while (s[ACTIVE_POS] !== 1'b0 && n < 20);
      if (n >= 20) hang();
   endtask
   task automatic wr_status(input logic [7:0] v);
      logic [7:0] r;
      cmd(OPC_ARM);
      xfer(OPC_STAT_WR, 1'b0, r);
      xfer(v, 1'b1, r);
   endtask
   // A count of zero data bytes closes the frame right after the address.
   task automatic wr_array(input logic [8:0] a, input logic [15:0] d, input int nb);
      logic [7:0] r;
      cmd(OPC_ARM);
      xfer(OPC_WRITE | {4'h0, a[8], 3'h0}, 1'b0, r);
      xfer(a[7:0], nb == 0, r);
      for (int i = 0; i < nb; i++) xfer(d[15-8*i -: 8], i == nb - 1, r);
   endtask
   task automatic rd_array(input logic [8:0] a, output logic [15:0] d);
      logic [7:0] r;
      xfer(OPC_READ | {4'h0, a[8], 3'h0}, 1'b0, r);
      xfer(a[7:0], 1'b0, r);
      xfer(8'h00, 1'b0, d[15:8]);
      xfer(8'h00, 1'b1, d[7:0]);
   endtask
   task automatic t_reset();
      logic [7:0] s;
      logic [31:0] d;
      `CHK(spi_link_if_i.miso_oe, 1'b0)
      `CHK(hresp, 1'b0)
      `CHK(tsel, 2'b11)
      rd_status(s);
      `CHK(s, STATUS_RST)
      bus(1'b0, 4'hC, 32'h00000000, d);
      `CHK(d, 32'h00000000)
      bus(1'b0, REG_CONFIG, 32'h00000000, d);
      `CHK(d[0], CONFIG_WP_RST)
   endtask
   task automatic t_permit();
      logic [7:0] s;
      logic [31:0] d;
      cmd(OPC_ARM);
      rd_status(s);
      `CHK(s, 8'h32)
      cmd(OPC_DISARM);
      rd_status(s);
      `CHK(s, 8'h30)
      cmd(OPC_ARM);
      bus(1'b1, REG_CONFIG, 32'h00000000, d);
      rd_status(s);
      `CHK(s, 8'h30)
      bus(1'b1, REG_CONFIG, 32'h00000001, d);
   endtask
   task automatic t_array();
      logic [7:0] s;
      logic [15:0] d;
      wr_array(9'h1FF, 16'h5AC3, 2);
      `CHK(write_active, 1'b1)
      rd_status(s);
      `CHK(s[ACTIVE_POS], 1'b1)
      wait_idle(s);
      `CHK(s, 8'h30)
      wr_array(9'h000, 16'h3C00, 1);
      wait_idle(s);
      wr_array(9'h180, 16'h5A00, 1);
      wait_idle(s);
      rd_array(9'h1FF, d);
      `CHK(d, 16'h5A3C)
      rd_array(9'h1F0, d);
      `CHK(d[15:8], 8'hC3)
   endtask
   task automatic t_protect();
      logic [7:0] s;
      logic [15:0] d;
      logic [31:0] w;
      wr_status(8'h04);
      wait_idle(s);
      `CHK(s, 8'h04)
      `CHK(tsel, 2'b00)
      wr_array(9'h1FF, 16'h1100, 1);
      rd_status(s);
      `CHK(s[ACTIVE_POS], 1'b0)
      wr_array(9'h17F, 16'h9900, 1);
      wait_idle(s);
      rd_array(9'h17F, d);
      `CHK(d, 16'h995A)
      wr_array(9'h000, 16'h7700, 0);
      rd_status(s);
      `CHK(s[ACTIVE_POS], 1'b0)
      bus(1'b1, REG_CONFIG, 32'h00000000, w);
      wr_array(9'h000, 16'h7700, 1);
      rd_status(s);
      `CHK(s[ACTIVE_POS], 1'b0)
      bus(1'b1, REG_CONFIG, 32'h00000001, w);
      // An arm inside the write's own frame must not let the write through.
      xfer(OPC_ARM, 1'b0, s);
      xfer(OPC_WRITE, 1'b0, s);
      xfer(8'h00, 1'b0, s);
      xfer(8'h77, 1'b1, s);
      rd_status(s);
      `CHK(s, 8'h06)
      rd_array(9'h1FF, d);
      `CHK(d, 16'h5A3C)
   endtask
   task automatic t_levels();
      logic [7:0] s;
      logic [15:0] d;
      wr_status(8'h28);
      wait_idle(s);
      `CHK(s, 8'h28)
      `CHK(tsel, 2'b10)
      wr_array(9'h17F, 16'h1100, 1);
      rd_status(s);
      `CHK(s[ACTIVE_POS], 1'b0)
      wr_status(8'h1C);
      wait_idle(s);
      `CHK(tsel, 2'b01)
      wr_array(9'h000, 16'h1100, 1);
      rd_status(s);
      `CHK(s, 8'h1E)
      rd_array(9'h17F, d);
      `CHK(d, 16'h995A)
   endtask
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      num_errors = 0;
      n_tests = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      // The memory's input filters need a few cycles before a select fall is seen.
      repeat (8) @(posedge clk_i);
      t_reset();
      t_permit();
      t_array();
      t_protect();
      t_levels();
      summarize();
   end
endmodule
